/* sbgp_port.sv */
`timescale 1ns/1ps
`default_nettype none

`include "sbgp_defs.svh"

module sbgp_port (
  input  wire logic               I_REF_CLK,
  input  wire logic               I_RST_N,
  input  wire sbgp_pkg::sbgp_addr_t I_ADDR,
  input  wire sbgp_pkg::sbgp_data_t I_WDATA,
  input  wire logic               I_WR,
  input  wire logic               I_RD,
  output var  sbgp_pkg::sbgp_data_t O_RDATA,
  input  wire sbgp_pkg::sbgp_pins_t I_FIRST_PORT_PINS,
  output var  sbgp_pkg::sbgp_pins_t O_FIRST_PORT_PINS,
  output var  sbgp_pkg::sbgp_pins_t O_FIRST_PORT_PINS_OE_N,
  input  wire sbgp_pkg::sbgp_pins_t I_PERIPH_EN,
  input  wire sbgp_pkg::sbgp_pins_t I_PERIPH_OUT,
  input  wire sbgp_pkg::sbgp_pins_t I_PERIPH_OE_N,
  output var  logic               O_TIMER_EXTERNAL_CLOCK_INPUT,
  output var  sbgp_pkg::sbgp_pins_t O_ANALOG_SEL,
  output var  logic               O_CONV_RIGHT_JUST
);

  import sbgp_pkg::*;

  // Architectural state.
  sbgp_pins_t first_port_data;
  sbgp_pins_t first_port_direction;
  sbgp_data_t analog_pin_config;

  // Derived and sampled state.
  sbgp_pins_t pin_sync;
  sbgp_pins_t analog_sel;
  sbgp_pins_t pin_view;
  sbgp_sel_t  sel;
  sbgp_pins_t next_first_port_data;
  sbgp_pins_t next_analog_sel;
  sbgp_data_t next_rdata;
  sbgp_pins_t drive_req;
  sbgp_pins_t drive_val;

  // Pins come from outside the clock domain and pass two flip-flops.
  sbgp_sync #(
    .WIDTH (`SBGP_NPINS)
  ) u_pin_sync (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .i_async (I_FIRST_PORT_PINS),
    .o_sync  (pin_sync)
  );

  // Address decode; anything unmapped selects nothing.
  always_comb begin
    unique case (I_ADDR)
      `SBGP_ADDR_DATA:  sel = SBGP_SEL_DATA;
      `SBGP_ADDR_DIR:   sel = SBGP_SEL_DIR;
      `SBGP_ADDR_ACFG:  sel = SBGP_SEL_ACFG;
      `SBGP_ADDR_SET:   sel = SBGP_SEL_SET;
      `SBGP_ADDR_CLR:   sel = SBGP_SEL_CLR;
      `SBGP_ADDR_LATCH: sel = SBGP_SEL_LATCH;
      default:          sel = SBGP_SEL_NONE;
    endcase
  end

  // The selected configuration code either frees every shared pin for
  // digital use or hands all of them to the converter. Bit 4 is never
  // converter-shared.
  always_comb begin
    if (analog_pin_config[`SBGP_PCFG_HI:`SBGP_PCFG_LO] == `SBGP_PCFG_DIGITAL) begin
      next_analog_sel = `SBGP_PINS_ZERO;
    end else begin
      next_analog_sel = `SBGP_SHARED_MASK;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      analog_sel <= `SBGP_SHARED_MASK;
    end else begin
      analog_sel <= next_analog_sel;
    end
  end

  // The digital view of the pins: converter-owned pins read as zero.
  assign pin_view = pin_sync & ~analog_sel;

  // Every latch write starts from the sampled pin state. A full data write
  // addresses all six bits, so the written value replaces all of them; the
  // set and clear aliases modify only the bits marked in the write data and
  // copy the rest from the pins, which is the hazard software must expect on
  // pins that another driver is pulling.
  always_comb begin
    next_first_port_data = first_port_data;
    if (I_WR) begin
      unique case (sel)
        SBGP_SEL_DATA: begin
          next_first_port_data = I_WDATA[`SBGP_NPINS-1:0];
        end
        SBGP_SEL_SET: begin
          next_first_port_data = pin_view | I_WDATA[`SBGP_NPINS-1:0];
        end
        SBGP_SEL_CLR: begin
          next_first_port_data = pin_view & ~I_WDATA[`SBGP_NPINS-1:0];
        end
        SBGP_SEL_NONE,
        SBGP_SEL_DIR,
        SBGP_SEL_ACFG,
        SBGP_SEL_LATCH: begin
          next_first_port_data = first_port_data;
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      first_port_data <= `SBGP_LATCH_RST;
    end else begin
      first_port_data <= next_first_port_data;
    end
  end

  // Direction register; the upper two write bits are dropped.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      first_port_direction <= `SBGP_DIR_RST;
    end else if (I_WR && (sel == SBGP_SEL_DIR)) begin
      first_port_direction <= I_WDATA[`SBGP_NPINS-1:0];
    end
  end

  // Analog configuration; unimplemented bit positions never store.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      analog_pin_config <= `SBGP_ACFG_RST;
    end else if (I_WR && (sel == SBGP_SEL_ACFG)) begin
      analog_pin_config <= I_WDATA & `SBGP_ACFG_MASK;
    end
  end

  // Read mux; data appear in the cycle after the strobe and only there.
  always_comb begin
    next_rdata = `SBGP_DATA_ZERO;
    if (I_RD) begin
      unique case (sel)
        SBGP_SEL_DATA: begin
          next_rdata = {2'b00, pin_view};
        end
        SBGP_SEL_DIR: begin
          next_rdata = {2'b00, first_port_direction};
        end
        SBGP_SEL_ACFG: begin
          next_rdata = analog_pin_config;
        end
        SBGP_SEL_LATCH: begin
          next_rdata = {2'b00, first_port_data};
        end
        SBGP_SEL_NONE,
        SBGP_SEL_SET,
        SBGP_SEL_CLR: begin
          next_rdata = `SBGP_DATA_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_RDATA <= `SBGP_DATA_ZERO;
    end else begin
      O_RDATA <= next_rdata;
    end
  end

  // Per-pin drive request. An enabled peripheral owns the pin outright;
  // otherwise the direction bit decides, even on a converter-owned pin, so
  // software must keep analog pins set as inputs to avoid loading them.
  always_comb begin
    for (int b = 0; b < `SBGP_NPINS; b++) begin
      if (I_PERIPH_EN[b]) begin
        drive_req[b] = ~I_PERIPH_OE_N[b];
        drive_val[b] = I_PERIPH_OUT[b];
      end else begin
        drive_req[b] = ~first_port_direction[b];
        drive_val[b] = first_port_data[b];
      end
    end
  end

  // Pin drivers, one flip-flop pair per pin.
  generate
    for (genvar g = 0; g < `SBGP_NPINS; g++) begin : g_pin
      if (g == `SBGP_OD_BIT) begin : g_open_drain
        // Only a low is driven; a one releases the pin to the pull-up.
        always_ff @(posedge I_REF_CLK) begin
          if (!I_RST_N) begin
            O_FIRST_PORT_PINS[g]      <= 1'b0;
            O_FIRST_PORT_PINS_OE_N[g] <= 1'b1;
          end else begin
            O_FIRST_PORT_PINS[g]      <= 1'b0;
            O_FIRST_PORT_PINS_OE_N[g] <= ~(drive_req[g] & ~drive_val[g]);
          end
        end
      end else begin : g_push_pull
        always_ff @(posedge I_REF_CLK) begin
          if (!I_RST_N) begin
            O_FIRST_PORT_PINS[g]      <= 1'b0;
            O_FIRST_PORT_PINS_OE_N[g] <= 1'b1;
          end else begin
            O_FIRST_PORT_PINS[g]      <= drive_val[g];
            O_FIRST_PORT_PINS_OE_N[g] <= ~drive_req[g];
          end
        end
      end
    end
  endgenerate

  // The bit 4 pin level also feeds the timer, whatever the port does with it.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_TIMER_EXTERNAL_CLOCK_INPUT <= 1'b0;
    end else begin
      O_TIMER_EXTERNAL_CLOCK_INPUT <= pin_sync[`SBGP_OD_BIT];
    end
  end

  // Converter-facing configuration.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_ANALOG_SEL      <= `SBGP_SHARED_MASK;
      O_CONV_RIGHT_JUST <= 1'b0;
    end else begin
      O_ANALOG_SEL      <= analog_sel;
      O_CONV_RIGHT_JUST <= analog_pin_config[`SBGP_ACFG_JUST];
    end
  end

endmodule : sbgp_port

`default_nettype wire

/* sbgp_defs.svh */
`ifndef SBGP_DEFS_SVH
`define SBGP_DEFS_SVH

// Port geometry and bus widths.
`define SBGP_NPINS        6
`define SBGP_DW           8
`define SBGP_AW           8

// Register addresses on the plain register port.
`define SBGP_ADDR_DATA    8'h05
`define SBGP_ADDR_DIR     8'h85
`define SBGP_ADDR_ACFG    8'h9F
`define SBGP_ADDR_SET     8'hC5
`define SBGP_ADDR_CLR     8'hC6
`define SBGP_ADDR_LATCH   8'hC7

// Reset values.
`define SBGP_DIR_RST      6'h3F
`define SBGP_LATCH_RST    6'h00
`define SBGP_ACFG_RST     8'h00
`define SBGP_PINS_ZERO    6'h00
`define SBGP_DATA_ZERO    8'h00

// Implemented bits of the analog pin configuration register.
`define SBGP_ACFG_MASK    8'h8F
`define SBGP_ACFG_JUST    7
`define SBGP_PCFG_HI      3
`define SBGP_PCFG_LO      1
`define SBGP_PCFG_DIGITAL 3'h3

// Pin roles: bit 4 is the open-drain timer clock pin, the rest are converter-shared.
`define SBGP_OD_BIT       4
`define SBGP_SHARED_MASK  6'h2F

`endif

/* sbgp_pkg.sv */
`default_nettype none

`include "sbgp_defs.svh"

package sbgp_pkg;

  typedef logic [`SBGP_NPINS-1:0] sbgp_pins_t;
  typedef logic [`SBGP_DW-1:0]    sbgp_data_t;
  typedef logic [`SBGP_AW-1:0]    sbgp_addr_t;

  typedef enum logic [2:0] {
    SBGP_SEL_NONE  = 3'b000,
    SBGP_SEL_DATA  = 3'b001,
    SBGP_SEL_DIR   = 3'b010,
    SBGP_SEL_ACFG  = 3'b011,
    SBGP_SEL_SET   = 3'b100,
    SBGP_SEL_CLR   = 3'b101,
    SBGP_SEL_LATCH = 3'b110
  } sbgp_sel_t;

endpackage : sbgp_pkg

`default_nettype wire

/* sbgp_sync.sv */
`timescale 1ns/1ps
`default_nettype none

`include "sbgp_defs.svh"

// Two-stage synchroniser; only the second stage is visible outside.
module sbgp_sync #(
  parameter int WIDTH = `SBGP_NPINS
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule : sbgp_sync

`default_nettype wire

/* sbgp_board.sv */
`timescale 1ns/1ps
`default_nettype none
module sbgp_board (
  input  wire sbgp_pkg::sbgp_pins_t i_out,
  input  wire sbgp_pkg::sbgp_pins_t i_oe_n,
  input  wire sbgp_pkg::sbgp_pins_t i_ext,
  input  wire sbgp_pkg::sbgp_pins_t i_ext_en,
  output var  sbgp_pkg::sbgp_pins_t o_pins
);
  import sbgp_pkg::*;
  // Every line has a pull-up, so a released line reads high.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      o_pins[i] = !i_oe_n[i] ? i_out[i] : (i_ext_en[i] ? i_ext[i] : 1'b1);
    end
  end
endmodule : sbgp_board
`default_nettype wire

/* sbgp_port_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sbgp_port_checker (
  input wire logic                 I_REF_CLK,
  input wire logic                 I_RST_N,
  input wire sbgp_pkg::sbgp_addr_t I_ADDR,
  input wire sbgp_pkg::sbgp_data_t I_WDATA,
  input wire logic                 I_WR,
  input wire logic                 I_RD,
  input wire sbgp_pkg::sbgp_data_t O_RDATA,
  input wire sbgp_pkg::sbgp_pins_t I_FIRST_PORT_PINS,
  input wire sbgp_pkg::sbgp_pins_t O_FIRST_PORT_PINS,
  input wire sbgp_pkg::sbgp_pins_t O_FIRST_PORT_PINS_OE_N,
  input wire sbgp_pkg::sbgp_pins_t I_PERIPH_EN,
  input wire sbgp_pkg::sbgp_pins_t I_PERIPH_OUT,
  input wire sbgp_pkg::sbgp_pins_t I_PERIPH_OE_N,
  input wire logic                 O_TIMER_EXTERNAL_CLOCK_INPUT,
  input wire sbgp_pkg::sbgp_pins_t O_ANALOG_SEL
);
  import sbgp_pkg::*;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  property p_od;
    O_FIRST_PORT_PINS[4] == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("bit 4 driven high");
  property p_rd_hi;
    I_RD && (I_ADDR == 8'h05 || I_ADDR == 8'h85) |=> O_RDATA[7:6] == 2'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper bits set");
  property p_unmap;
    I_RD && I_ADDR == 8'h10 |=> O_RDATA == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_dir_in;
    I_WR && I_ADDR == 8'h85 && I_WDATA[5:0] == 6'h3F && I_PERIPH_EN == 6'h00
      ##1 I_PERIPH_EN == 6'h00 |=> O_FIRST_PORT_PINS_OE_N == 6'h3F;
  endproperty
  a_dir_in: assert property (p_dir_in) else $error("input still driven");
  property p_timer;
    $past(I_RST_N) && $past(I_RST_N, 2) && $past(I_RST_N, 3)
      |-> O_TIMER_EXTERNAL_CLOCK_INPUT == $past(I_FIRST_PORT_PINS[4], 3);
  endproperty
  a_timer: assert property (p_timer) else $error("timer clock lag");
  property p_periph;
    I_PERIPH_EN == 6'h3F |=> O_FIRST_PORT_PINS[3:0] == $past(I_PERIPH_OUT[3:0])
      && O_FIRST_PORT_PINS_OE_N[3:0] == $past(I_PERIPH_OE_N[3:0]);
  endproperty
  a_periph: assert property (p_periph) else $error("periph ignored");
  property p_od_oe;
    I_PERIPH_EN[4] |=> O_FIRST_PORT_PINS_OE_N[4]
      == ($past(I_PERIPH_OE_N[4]) || $past(I_PERIPH_OUT[4]));
  endproperty
  a_od_oe: assert property (p_od_oe) else $error("bit 4 drives one");
  property p_analog;
    I_WR && I_ADDR == 8'h9F ##1 !I_WR |=> ##1
      O_ANALOG_SEL == (($past(I_WDATA[3:1], 3) == 3'h3) ? 6'h00 : 6'h2F);
  endproperty
  a_analog: assert property (p_analog) else $error("analog select");
endmodule : sbgp_port_checker
bind sbgp_port sbgp_port_checker i_chk (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .I_FIRST_PORT_PINS(I_FIRST_PORT_PINS), .O_FIRST_PORT_PINS(O_FIRST_PORT_PINS),
  .O_FIRST_PORT_PINS_OE_N(O_FIRST_PORT_PINS_OE_N), .I_PERIPH_EN(I_PERIPH_EN),
  .I_PERIPH_OUT(I_PERIPH_OUT), .I_PERIPH_OE_N(I_PERIPH_OE_N),
  .O_TIMER_EXTERNAL_CLOCK_INPUT(O_TIMER_EXTERNAL_CLOCK_INPUT), .O_ANALOG_SEL(O_ANALOG_SEL));
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sbgp_pkg::*;
  logic       clk, rst_n, wr, rd, rd_d, tmr, rjust;
  sbgp_addr_t addr;
  sbgp_data_t wdata, rdata, lat, v;
  sbgp_pins_t pins, pout, poe_n, pen, perout, peroe_n, ext, ext_en, asel;
  sbgp_data_t q[$];
  int         n_fail, n_compared, cyc;
  integer     seed;
  logic [31:0] r;
  sbgp_port i_dut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_FIRST_PORT_PINS(pins),
    .O_FIRST_PORT_PINS(pout), .O_FIRST_PORT_PINS_OE_N(poe_n), .I_PERIPH_EN(pen),
    .I_PERIPH_OUT(perout), .I_PERIPH_OE_N(peroe_n), .O_TIMER_EXTERNAL_CLOCK_INPUT(tmr),
    .O_ANALOG_SEL(asel), .O_CONV_RIGHT_JUST(rjust));
  sbgp_board i_board (.i_out(pout), .i_oe_n(poe_n), .i_ext(ext), .i_ext_en(ext_en),
    .o_pins(pins));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string nm, input sbgp_data_t e, input sbgp_data_t s);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  task automatic bus(input logic w, input logic rr, input sbgp_addr_t a, input sbgp_data_t d);
    @(posedge clk);
    wr <= w;
    rd <= rr;
    addr <= a;
    wdata <= d;
  endtask : bus
  task automatic rdx(input sbgp_addr_t a, input sbgp_data_t e);
    bus(1'b0, 1'b1, a, 8'h00);
    q.push_back(e);
  endtask : rdx
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask : idle
  // Read data stand only in the cycle after the strobe.
  always @(posedge clk) begin
    if (rd_d) chk("rdata", q.pop_front(), rdata);
    rd_d <= rd;
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    seed = 32'h50b6;
    {rst_n, wr, rd, rd_d, addr, wdata, pen, perout} = '0;
    {cyc, n_fail, n_compared} = '0;
    {peroe_n, ext, ext_en} = {6'h3F, 6'h3F, 6'h3F};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    idle(3);
    #1 chk("oe_n", 8'h3F, {2'h0, poe_n});
    rdx(8'h05, 8'h10);
    rdx(8'h85, 8'h3F);
    rdx(8'h9F, 8'h00);
    rdx(8'h10, 8'h00);
    $display("test reset done");
    bus(1'b1, 1'b0, 8'h9F, 8'hFF);
    rdx(8'h9F, 8'h8F);
    bus(1'b1, 1'b0, 8'h9F, 8'h06);
    #1 chk("rjust", 8'h01, {7'h0, rjust});
    r = $random(seed);
    v = {2'h0, r[5:0]};
    ext <= v[5:0];
    idle(4);
    rdx(8'h05, v);
    r = $random(seed);
    lat = r[7:0];
    bus(1'b1, 1'b0, 8'h05, lat);
    rdx(8'hC7, {2'h0, lat[5:0]});
    rdx(8'h05, v);
    bus(1'b1, 1'b0, 8'h85, 8'hC0);
    ext_en <= 6'h00;
    rdx(8'h85, 8'h00);
    idle(4);
    #1 chk("pins", {2'h0, lat[5:0] & 6'h2F}, {2'h0, pout});
    chk("oe_n", {2'h0, lat[5:0] & 6'h10}, {2'h0, poe_n});
    rdx(8'h05, {2'h0, lat[5:0]});
    $display("test latch done");
    bus(1'b1, 1'b0, 8'h85, 8'h02);
    ext_en <= 6'h02;
    ext <= 6'h00;
    idle(4);
    bus(1'b1, 1'b0, 8'hC5, 8'h01);
    idle(4);
    lat = (lat & 8'h3D) | 8'h01;
    rdx(8'hC7, lat);
    bus(1'b1, 1'b0, 8'hC6, 8'h04);
    idle(4);
    lat = lat & 8'h39;
    rdx(8'hC7, lat);
    // The latch readback address takes no writes, the set alias reads as zero.
    bus(1'b1, 1'b0, 8'hC7, 8'h3F);
    rdx(8'hC7, lat);
    rdx(8'hC5, 8'h00);
    $display("test rmw done");
    bus(1'b1, 1'b0, 8'h9F, 8'h00);
    idle(3);
    rdx(8'h05, lat & 8'h10);
    idle(2);
    #1 chk("oe_n", {2'h0, 6'h02 | (lat[5:0] & 6'h10)}, {2'h0, poe_n});
    chk("rjust", 8'h00, {7'h0, rjust});
    // Drivers go off again after the analog lines have been handed to the converter.
    bus(1'b1, 1'b0, 8'h85, 8'h3F);
    idle(3);
    $display("test analog done");
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      @(posedge clk);
      pen <= 6'h3F;
      perout <= r[5:0];
      peroe_n <= r[11:6];
    end
    @(posedge clk);
    pen <= 6'h00;
    idle(3);
    $display("test peripheral done");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
